// ===== hdl/snp_packer.sv
// serial-to-network packer: register slave, packing buffer, host fan-out
`timescale 1ns/100ps
module snp_packer
#(
   parameter int MS_CYCLES = snp_pkg::MS_CYCLES
)
(
   input  wire logic        clock_i,
   input  wire logic        srst_i,
   // ahb-lite slave
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic [31:0]      hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   // bytes from the serial receiver
   input  wire logic        rx_valid_i,
   input  wire logic [7:0]  rx_data_i,
   output logic             rx_ready_o,
   // packets toward the admitted network hosts
   output logic             pkt_valid_o,
   output logic [7:0]       pkt_data_o,
   output logic             pkt_last_o,
   input  wire logic [7:0]  host_conn_i,
   input  wire logic [7:0]  host_ready_i,
   output logic [7:0]       host_active_o,
   // network bytes toward the serial transmitter
   input  wire logic        net_valid_i,
   input  wire logic [7:0]  net_data_i,
   output logic             net_ready_o,
   output logic             tx_valid_o,
   output logic [7:0]       tx_data_o,
   input  wire logic        tx_ready_i,
   // host control commands and modem lines
   input  wire logic        cmd_valid_i,
   input  wire logic [1:0]  cmd_modem_i,
   input  wire logic        link_up_i,
   output logic             rts_o,
   output logic             dtr_o
);
   typedef enum logic {SNP_FILL, SNP_SEND} snp_state_t;

   localparam logic [31:0] MS_CYC = 32'(MS_CYCLES);
   localparam logic [31:0] STALL  = 32'(snp_pkg::STALL_CYC);
   localparam logic [10:0] FULL   = 11'(snp_pkg::BUF_BYTES);

   logic [7:0]                  buf_mem [snp_pkg::BUF_BYTES];
   snp_state_t                  state;
   logic [snp_pkg::CNT_W-1:0]   count;
   logic [snp_pkg::CNT_W-1:0]   send_len;
   logic [snp_pkg::CNT_W-1:0]   rd_idx;
   logic [7:0]                  prev_byte;
   logic                        prev_ok;
   logic [1:0]                  post_left;
   logic                        post_wait;
   // configuration
   logic [10:0]                 pkt_len;
   logic                        d1_en;
   logic                        d2_en;
   snp_pkg::snp_proc_t          proc_sel;
   logic                        skip_en;
   logic                        allow_cmd;
   logic                        link_low;
   logic [3:0]                  max_conn;
   logic [7:0]                  delim1;
   logic [7:0]                  delim2;
   logic [15:0]                 force_ms;
   logic [1:0]                  modem;
   // bus data phase
   logic                        wr_pend;
   logic [7:0]                  wr_addr;
   logic                        bus_req;
   logic [31:0]                 rd_word;
   // idle timer
   logic [31:0]                 pre_cnt;
   logic [16:0]                 idle_ms;
   logic                        idle_hit;
   // host fan-out
   logic [7:0]                  dropped;
   logic [7:0]                  admitted;
   logic                        all_ready;
   logic                        accept;
   logic [31:0]                 stall_cnt;
   // packing decisions
   logic                        take;
   logic                        delim_on;
   logic                        match;
   logic                        store;
   logic                        release_now;
   logic [snp_pkg::CNT_W-1:0]   next_count;
   logic [snp_pkg::CNT_W-1:0]   next_len;

   // bus answers at once, always okay
   assign hreadyout_o = 1'b1;
   assign hresp_o     = 1'b0;
   assign bus_req     = hsel_i && htrans_i[1] && hready_i;

   // address phase capture and read data staging
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         wr_pend  <= 1'b0;
         wr_addr  <= 8'h00;
         hrdata_o <= 32'h0000_0000;
      end
      else
      begin
         wr_pend <= bus_req && hwrite_i;
         wr_addr <= haddr_i[7:0];
         if (bus_req && !hwrite_i)
         begin
            hrdata_o <= rd_word;
         end
      end
   end

   // read multiplexer; unmapped addresses read zero
   always_comb
   begin
      rd_word = 32'h0000_0000;
      case (haddr_i[7:0])
         snp_pkg::OFS_CTRL:
         begin
            rd_word[snp_pkg::CTRL_LEN_LSB +: 11] = pkt_len;
            rd_word[snp_pkg::CTRL_D1EN]          = d1_en;
            rd_word[snp_pkg::CTRL_D2EN]          = d2_en;
            rd_word[snp_pkg::CTRL_PROC_LSB +: 2] = proc_sel;
            rd_word[snp_pkg::CTRL_SKIP]          = skip_en;
            rd_word[snp_pkg::CTRL_ALLOW]         = allow_cmd;
            rd_word[snp_pkg::CTRL_LINKLOW]       = link_low;
            rd_word[snp_pkg::CTRL_MAXC_LSB +: 4] = max_conn;
         end
         snp_pkg::OFS_DELIM:  rd_word[15:0] = {delim2, delim1};
         snp_pkg::OFS_FORCE:  rd_word[15:0] = force_ms;
         snp_pkg::OFS_STATUS:
         begin
            rd_word[10:0]                        = count;
            rd_word[snp_pkg::STAT_BUSY]          = state == SNP_SEND;
            rd_word[snp_pkg::STAT_HOST_LSB +: 8] = host_active_o;
         end
         snp_pkg::OFS_MODEM:  rd_word[1:0] = modem;
         default:             rd_word = 32'h0000_0000;
      endcase
   end

   // configuration registers
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         pkt_len   <= 11'h000;
         d1_en     <= 1'b0;
         d2_en     <= 1'b0;
         proc_sel  <= snp_pkg::SNP_PROC_NONE;
         skip_en   <= 1'b0;
         allow_cmd <= 1'b0;
         link_low  <= 1'b0;
         max_conn  <= snp_pkg::MAXC_RST;
         delim1    <= 8'h00;
         delim2    <= 8'h00;
         force_ms  <= 16'h0000;
      end
      else if (wr_pend && wr_addr == snp_pkg::OFS_CTRL)
      begin
         pkt_len   <= hwdata_i[snp_pkg::CTRL_LEN_LSB +: 11];
         d1_en     <= hwdata_i[snp_pkg::CTRL_D1EN];
         d2_en     <= hwdata_i[snp_pkg::CTRL_D2EN];
         proc_sel  <= snp_pkg::snp_proc_t'(hwdata_i[snp_pkg::CTRL_PROC_LSB +: 2]);
         skip_en   <= hwdata_i[snp_pkg::CTRL_SKIP];
         allow_cmd <= hwdata_i[snp_pkg::CTRL_ALLOW];
         link_low  <= hwdata_i[snp_pkg::CTRL_LINKLOW];
         max_conn  <= hwdata_i[snp_pkg::CTRL_MAXC_LSB +: 4];
      end
      else if (wr_pend && wr_addr == snp_pkg::OFS_DELIM)
      begin
         delim1 <= hwdata_i[7:0];
         delim2 <= hwdata_i[15:8];
      end
      else if (wr_pend && wr_addr == snp_pkg::OFS_FORCE)
      begin
         force_ms <= hwdata_i[15:0];
      end
   end

   // modem line state: host command wins over a software write in one cycle
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         modem <= snp_pkg::MODEM_RST;
      end
      else if (cmd_valid_i && allow_cmd)
      begin
         modem <= cmd_modem_i;
      end
      else if (wr_pend && wr_addr == snp_pkg::OFS_MODEM)
      begin
         modem <= hwdata_i[1:0];
      end
   end

   // link-loss option forces both lines low
   assign rts_o = modem[snp_pkg::MODEM_RTS] && !(link_low && !link_up_i);
   assign dtr_o = modem[snp_pkg::MODEM_DTR] && !(link_low && !link_up_i);

   // idle timer: millisecond prescaler and idle count
   always_ff @(posedge clock_i)
   begin
      if (srst_i || take || count == 11'h000 || state == SNP_SEND)
      begin
         pre_cnt <= 32'h0000_0000;
         idle_ms <= 17'h00000;
      end
      else if (pre_cnt == MS_CYC - 32'h0000_0001)
      begin
         pre_cnt <= 32'h0000_0000;
         if (!idle_hit)
         begin
            idle_ms <= idle_ms + 17'h00001;
         end
      end
      else
      begin
         pre_cnt <= pre_cnt + 32'h0000_0001;
      end
   end

   // gap must exceed the setting; zero disables the timer
   assign idle_hit = force_ms != 16'h0000 && idle_ms > {1'b0, force_ms};

   // byte classification
   assign take     = rx_valid_i && rx_ready_o;
   assign delim_on = pkt_len == 11'h000 && d1_en;
   assign match    = delim_on && !post_wait && (d2_en
                   ? (prev_ok && prev_byte == delim1 && rx_data_i == delim2)
                   : rx_data_i == delim1);
   assign rx_ready_o = state == SNP_FILL && count != FULL;

   // store decision, release decision and released length
   always_comb
   begin
      store       = take;
      release_now = 1'b0;
      next_count  = count + 11'h001;
      next_len    = count + 11'h001;
      if (take && match && proc_sel == snp_pkg::SNP_PROC_STRIP)
      begin
         store       = 1'b0;
         next_count  = count;
         next_len    = d2_en ? count - 11'h001 : count;
         release_now = 1'b1;
      end
      else if (take && match && proc_sel == snp_pkg::SNP_PROC_NONE)
      begin
         release_now = 1'b1;
      end
      else if (take && post_wait && post_left == 2'h1)
      begin
         release_now = 1'b1;
      end
      else if (take && pkt_len != 11'h000 && next_count == pkt_len)
      begin
         release_now = 1'b1;
      end
      else if (take && next_count == FULL)
      begin
         release_now = 1'b1;
      end
      else if (!take && idle_hit && state == SNP_FILL)
      begin
         release_now = 1'b1;
         next_count  = count;
         next_len    = count;
      end
   end

   // buffer write
   always_ff @(posedge clock_i)
   begin
      if (store)
      begin
         buf_mem[count[snp_pkg::PTR_W-1:0]] <= rx_data_i;
      end
   end

   // packing state
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         state     <= SNP_FILL;
         count     <= 11'h000;
         send_len  <= 11'h000;
         prev_byte <= 8'h00;
         prev_ok   <= 1'b0;
         post_wait <= 1'b0;
         post_left <= 2'h0;
      end
      else
      begin
         case (state)
            SNP_FILL:
            begin
               if (take)
               begin
                  prev_byte <= rx_data_i;
                  prev_ok   <= !match;
               end
               if (take && match && proc_sel == snp_pkg::SNP_PROC_PLUS1)
               begin
                  post_wait <= 1'b1;
                  post_left <= 2'h1;
               end
               else if (take && match && proc_sel == snp_pkg::SNP_PROC_PLUS2)
               begin
                  post_wait <= 1'b1;
                  post_left <= 2'h2;
               end
               else if (take && post_wait)
               begin
                  post_left <= post_left - 2'h1;
               end
               if (release_now)
               begin
                  post_wait <= 1'b0;
                  prev_ok   <= 1'b0;
                  count     <= next_count;
                  send_len  <= next_len;
                  state     <= SNP_SEND;
               end
               else if (store)
               begin
                  count <= next_count;
               end
            end
            SNP_SEND:
            begin
               if (rd_idx == send_len && (!pkt_valid_o || accept))
               begin
                  count <= 11'h000;
                  state <= SNP_FILL;
               end
            end
            default: state <= SNP_FILL;
         endcase
      end
   end

   // hosts admitted by the connection limit and not dropped
   for (genvar h = 0; h < snp_pkg::HOSTS; h++)
   begin : g_host
      assign admitted[h] = host_conn_i[h] && (4'(h) < max_conn) && !dropped[h];
   end
   assign host_active_o = admitted;
   assign all_ready     = &(host_ready_i | ~admitted);
   assign accept        = pkt_valid_o && all_ready;

   // stall watch and host dropping
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         stall_cnt <= 32'h0000_0000;
         dropped   <= 8'h00;
      end
      else
      begin
         dropped <= dropped & host_conn_i; // a fresh session starts clean
         if (!pkt_valid_o || all_ready)
         begin
            stall_cnt <= 32'h0000_0000;
         end
         else if (stall_cnt == STALL - 32'h0000_0001)
         begin
            stall_cnt <= 32'h0000_0000;
            if (skip_en)
            begin
               dropped <= (dropped | (admitted & ~host_ready_i)) & host_conn_i;
            end
         end
         else
         begin
            stall_cnt <= stall_cnt + 32'h0000_0001;
         end
      end
   end

   // packet byte output, next byte only once every active host took it
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         pkt_valid_o <= 1'b0;
         pkt_data_o  <= 8'h00;
         pkt_last_o  <= 1'b0;
         rd_idx      <= 11'h000;
      end
      else if (state == SNP_SEND && rd_idx != send_len && (!pkt_valid_o || accept))
      begin
         pkt_valid_o <= 1'b1;
         pkt_data_o  <= buf_mem[rd_idx[snp_pkg::PTR_W-1:0]];
         pkt_last_o  <= rd_idx + 11'h001 == send_len;
         rd_idx      <= rd_idx + 11'h001;
      end
      else if (accept || state == SNP_FILL)
      begin
         pkt_valid_o <= 1'b0;
         pkt_last_o  <= 1'b0;
         rd_idx      <= state == SNP_FILL ? 11'h000 : rd_idx;
      end
   end

   // network to serial path
   snp_tx_fifo u_tx_fifo
   (
      .clock_i     (clock_i),
      .srst_i      (srst_i),
      .in_valid_i  (net_valid_i),
      .in_data_i   (net_data_i),
      .in_ready_o  (net_ready_o),
      .out_valid_o (tx_valid_o),
      .out_data_o  (tx_data_o),
      .out_ready_i (tx_ready_i)
   );
endmodule

// ===== hdl/snp_pkg.sv
// constants, register map and types of the serial-to-network packer
package snp_pkg;
   // buffer geometry
   localparam int BUF_BYTES  = 1024;
   localparam int PTR_W      = 10;
   localparam int CNT_W      = 11;
   localparam int HOSTS      = 8;
   localparam int TXF_DEPTH  = 16;
   localparam int TXF_PTR_W  = 4;
   // timing
   localparam int CLK_HZ     = 10000000;
   localparam int MS_PER_S   = 1000;
   localparam int MS_CYCLES  = CLK_HZ / MS_PER_S;
   localparam int STALL_US   = 100;
   localparam int US_PER_S   = 1000000;
   localparam int STALL_CYC  = CLK_HZ / US_PER_S * STALL_US;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_DELIM  = 8'h04;
   localparam logic [7:0] OFS_FORCE  = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_MODEM  = 8'h10;
   // control register fields
   localparam int CTRL_LEN_LSB  = 0;
   localparam int CTRL_D1EN     = 16;
   localparam int CTRL_D2EN     = 17;
   localparam int CTRL_PROC_LSB = 18;
   localparam int CTRL_SKIP     = 20;
   localparam int CTRL_ALLOW    = 21;
   localparam int CTRL_LINKLOW  = 22;
   localparam int CTRL_MAXC_LSB = 24;
   // status and modem fields
   localparam int STAT_BUSY     = 12;
   localparam int STAT_HOST_LSB = 16;
   localparam int MODEM_RTS     = 0;
   localparam int MODEM_DTR     = 1;
   // reset values
   localparam logic [3:0]  MAXC_RST  = 4'h1;
   localparam logic [1:0]  MODEM_RST = 2'h3;
   // delimiter post-processing choices
   typedef enum logic [1:0] {
      SNP_PROC_NONE,
      SNP_PROC_PLUS1,
      SNP_PROC_PLUS2,
      SNP_PROC_STRIP
   } snp_proc_t;
endpackage

// ===== hdl/snp_tx_fifo.sv
// first-in first-out queue from network side to serial transmitter
`timescale 1ns/100ps
module snp_tx_fifo
(
   input  wire logic       clock_i,
   input  wire logic       srst_i,
   input  wire logic       in_valid_i,
   input  wire logic [7:0] in_data_i,
   output logic            in_ready_o,
   output logic            out_valid_o,
   output logic [7:0]      out_data_o,
   input  wire logic       out_ready_i
);
   logic [7:0]                     mem [snp_pkg::TXF_DEPTH];
   logic [snp_pkg::TXF_PTR_W-1:0]  wr_ptr;
   logic [snp_pkg::TXF_PTR_W-1:0]  rd_ptr;
   logic [snp_pkg::TXF_PTR_W:0]    level;
   logic                           push;
   logic                           pop;

   // handshakes
   assign in_ready_o  = level != 5'(snp_pkg::TXF_DEPTH);
   assign out_valid_o = level != 5'h00;
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;
   assign out_data_o  = mem[rd_ptr]; // storage flops, oldest entry first

   // storage write
   always_ff @(posedge clock_i)
   begin
      if (push)
      begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   // pointers advance strictly in arrival order
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level  <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr <= wr_ptr + 4'h1;
         end
         if (pop)
         begin
            rd_ptr <= rd_ptr + 4'h1;
         end
         level <= level + 5'(push) - 5'(pop);
      end
   end
endmodule

// ===== verification/snp_hosts.sv
// network hosts: random accept, commanded stall, byte capture
`timescale 1ns/100ps
module snp_hosts
(
   input wire logic       clock_i,
   input wire logic       pkt_valid_i,
   input wire logic [7:0] pkt_data_i,
   input wire logic       pkt_last_i,
   input wire logic [7:0] host_active_i,
   input wire logic [7:0] stall_i,
   output logic     [7:0] host_ready_o
);
   logic [7:0]  got[$];
   int          npkt;
   logic [31:0] lf;
   initial
   begin
      npkt = 0;
      lf = 32'h1;
      host_ready_o = 8'h00;
   end
   // hosts accept at random pace; a stalled host never accepts
   always @(posedge clock_i)
   begin
      lf <= {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
      host_ready_o <= ~stall_i & (lf[3] ? 8'hFF : lf[15:8]);
      if (pkt_valid_i && ((host_active_i & ~host_ready_o) == 8'h00))
      begin
         got.push_back(pkt_data_i);
         if (pkt_last_i)
            npkt <= npkt + 1;
      end
   end
endmodule

// ===== verification/snp_properties.sv
// port-level checker of the packer
`timescale 1ns/100ps
module snp_props
(
   input wire logic        clock_i,
   input wire logic        srst_i,
   input wire logic        hsel_i,
   input wire logic [1:0]  htrans_i,
   input wire logic        hwrite_i,
   input wire logic        hready_i,
   input wire logic [31:0] hrdata_o,
   input wire logic        hreadyout_o,
   input wire logic        hresp_o,
   input wire logic        rx_ready_o,
   input wire logic        pkt_valid_o,
   input wire logic [7:0]  pkt_data_o,
   input wire logic        pkt_last_o,
   input wire logic [7:0]  host_conn_i,
   input wire logic [7:0]  host_ready_i,
   input wire logic [7:0]  host_active_o,
   input wire logic        net_valid_i,
   input wire logic        tx_valid_o,
   input wire logic [7:0]  tx_data_o,
   input wire logic        tx_ready_i
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (srst_i);
   logic go;
   logic rd_ph;
   // byte taken by every admitted host; read address phase
   assign go    = pkt_valid_o && ((host_active_o & ~host_ready_i) == 8'h00);
   assign rd_ph = hsel_i && htrans_i[1] && !hwrite_i && hready_i;
   AST_BUS_OKAY: assert property (hreadyout_o && !hresp_o)
      else $error("bus slave stalled or answered an error");
   AST_RDATA_HOLD: assert property (!rd_ph |=> $stable(hrdata_o))
      else $error("read data moved without a read");
   AST_RESET_IDLE: assert property ($fell(srst_i) |-> rx_ready_o && !pkt_valid_o && !tx_valid_o)
      else $error("outputs not idle after reset");
   AST_NO_RX_SEND: assert property (pkt_valid_o |-> !rx_ready_o)
      else $error("serial byte accepted while sending");
   AST_WAIT_ALL: assert property (pkt_valid_o && !go |=> pkt_valid_o && $stable(pkt_data_o))
      else $error("packet byte moved before all hosts took it");
   AST_LAST_FILL: assert property (go && pkt_last_o |-> ##[1:2] (!pkt_valid_o && rx_ready_o))
      else $error("buffer not reopened after packet end");
   AST_RELEASE: assert property ($fell(rx_ready_o) |-> ##[0:3] pkt_valid_o)
      else $error("release did not start a packet");
   AST_ACT_CONN: assert property ((host_active_o & ~host_conn_i) == 8'h00)
      else $error("unconnected host marked active");
   AST_FIFO_HOLD: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
      else $error("serial output byte dropped or changed");
   AST_FIFO_EMPTY: assert property (!tx_valid_o && !net_valid_i |=> !tx_valid_o)
      else $error("serial output byte from nowhere");
endmodule

// ===== verification/tb_top.sv
// self-checking bench of the packer
`timescale 1ns/100ps
module tb_top;
   localparam logic [7:0] D1 = 8'h0D;
   localparam logic [7:0] D2 = 8'h0A;
   logic        clock_i, srst_i, hsel_i, hwrite_i, hready_i, rx_valid_i, cmd_valid_i;
   logic        net_valid_i, tx_ready_i, link_up_i, hreadyout_o, hresp_o, rx_ready_o;
   logic        pkt_valid_o, pkt_last_o, net_ready_o, tx_valid_o, rts_o, dtr_o;
   logic [1:0]  htrans_i, cmd_modem_i;
   logic [2:0]  hsize_i;
   logic [31:0] haddr_i, hwdata_i, hrdata_o, rd, seed;
   logic [7:0]  rx_data_i, pkt_data_o, host_conn_i, host_ready_i, host_active_o;
   logic [7:0]  net_data_i, tx_data_o, stall;
   logic [7:0]  s[$], e[$], q[$];
   logic [31:0] dc[6] = '{32'h0101_0000, 32'h0105_0000, 32'h0109_0000,
                          32'h010D_0000, 32'h0103_0000, 32'h010F_0000};
   int          bad_count, num_checks, u;
   assign hready_i = hreadyout_o;
   snp_packer #(.MS_CYCLES(10)) DUT (.*);
   snp_hosts H (.clock_i(clock_i), .pkt_valid_i(pkt_valid_o), .pkt_data_i(pkt_data_o),
      .pkt_last_i(pkt_last_o), .host_active_i(host_active_o), .stall_i(stall),
      .host_ready_o(host_ready_i));
   initial
   begin
      clock_i = 1'b0;
      forever #50 clock_i = ~clock_i;
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic void fill(input int k);
      repeat (k) s.push_back(8'(xs()) | 8'h80);
   endfunction
   // expected packet and bytes consumed for control word c
   function automatic void model(input logic [31:0] c);
      int n;
      n = -1;
      e.delete();
      u = s.size();
      foreach (s[i])
      begin
         e.push_back(s[i]);
         u = i + 1;
         if (c[10:0] != 0 && e.size() == c[10:0]) return;
         if (c[16] && n < 0 && (c[17] ? (i > 0 && s[i] == D2 && s[i-1] == D1) : s[i] == D1))
         begin
            n = (c[19:18] == 2'h1) ? 1 : (c[19:18] == 2'h2) ? 2 : 0;
            if (c[19:18] == 2'h3) repeat (c[17] ? 2 : 1) void'(e.pop_back());
         end
         else if (n > 0) n--;
         if (n == 0 || u == 1024) return;
      end
      e.delete(); // no release event: nothing is sent
   endfunction
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      hsel_i <= 1'b1;
      htrans_i <= 2'h2;
      haddr_i <= {24'h0, a};
      hwrite_i <= w;
      do @(posedge clock_i); while (hreadyout_o !== 1'b1);
      hsel_i <= 1'b0;
      htrans_i <= 2'h0;
      hwdata_i <= d;
      do @(posedge clock_i); while (hreadyout_o !== 1'b1);
      rd = hrdata_o;
   endtask
   task automatic send();
      @(posedge clock_i);
      for (int i = 0; i < u; i++)
      begin
         rx_valid_i <= 1'b1;
         rx_data_i <= s[i];
         do @(posedge clock_i); while (rx_ready_o !== 1'b1);
      end
      rx_valid_i <= 1'b0;
   endtask
   task automatic pk(input logic [31:0] c);
      int n0;
      model(c);
      bus(1'b1, snp_pkg::OFS_CTRL, c);
      H.got.delete();
      n0 = H.npkt;
      send();
      for (int k = 0; k < 3000 && H.npkt == n0; k++) @(posedge clock_i);
      chk("packet size", H.got.size(), e.size());
      foreach (e[i]) chk("packet byte", H.got[i], e[i]);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // watchdog against hangs
   initial
   begin
      repeat (60000) @(posedge clock_i);
      bad_count++;
      conclude();
   end
   initial
   begin
      {hsel_i, hwrite_i, rx_valid_i, cmd_valid_i, net_valid_i} = 5'h00;
      {htrans_i, cmd_modem_i, stall, rx_data_i, net_data_i} = 28'h0;
      {haddr_i, hwdata_i} = 64'h0;
      hsize_i = 3'h2;
      tx_ready_i = 1'b1;
      link_up_i = 1'b1;
      host_conn_i = 8'h01;
      seed = 32'hD95C;
      srst_i = 1'b1;
      repeat (10) @(posedge clock_i);
      srst_i <= 1'b0;
      // reset values and an unmapped place
      bus(1'b0, snp_pkg::OFS_CTRL, 32'h0);
      chk("ctrl reset", rd, {4'h0, snp_pkg::MAXC_RST, 24'h0});
      bus(1'b0, snp_pkg::OFS_MODEM, 32'h0);
      chk("modem reset", rd, {30'h0, snp_pkg::MODEM_RST});
      bus(1'b0, 8'h40, 32'h0);
      chk("unmapped", rd, 32'h0);
      bus(1'b1, snp_pkg::OFS_DELIM, {16'h0, D2, D1});
      // length release, with both end values of the range
      for (int t = 0; t < 4; t++)
      begin
         u = (t == 0) ? 1 : (t == 1) ? 1024 : 1 + xs() % 40;
         s.delete();
         fill(u);
         pk(32'h0100_0000 | u);
      end
      // every delimiter choice single, only none and strip paired, length zero
      foreach (dc[i])
      begin
         s.delete();
         fill(2);
         s.push_back(D1);
         fill(1);
         s = {s, D1, D2};
         fill(2);
         pk(dc[i]);
      end
      // full buffer while delimiter matching is on
      s.delete();
      fill(1030);
      pk(32'h0101_0000);
      // idle timer off, then a 2 ms gap
      s.delete();
      fill(5);
      pk(32'h0100_0000);
      chk("idle off", H.got.size(), 0);
      bus(1'b1, snp_pkg::OFS_FORCE, 32'h2);
      repeat (100) @(posedge clock_i);
      chk("idle release", H.got.size(), 5);
      H.got.delete();
      send();
      repeat (28) @(posedge clock_i);
      chk("idle early", H.got.size(), 0);
      repeat (30) @(posedge clock_i);
      chk("idle release", H.got.size(), 5);
      bus(1'b1, snp_pkg::OFS_FORCE, 32'h0);
      // stalled host: waited for, then dropped when skipping
      host_conn_i <= 8'h07;
      stall <= 8'h02;
      fork
         begin
            repeat (1500) @(posedge clock_i);
            stall <= 8'h00;
         end
      join_none
      s.delete();
      fill(8);
      pk(32'h0200_0008);
      chk("active kept", host_active_o, 8'h03);
      stall <= 8'h02;
      pk(32'h0210_0008);
      chk("active dropped", host_active_o, 8'h01);
      host_conn_i <= 8'h00;
      stall <= 8'h00;
      bus(1'b1, snp_pkg::OFS_CTRL, 32'h0800_0000);
      host_conn_i <= 8'hFF;
      bus(1'b0, snp_pkg::OFS_STATUS, 32'h0);
      chk("eight hosts", rd[23:16], 8'hFF);
      // network bytes toward the serial side under random stalls
      fork
         begin
            for (int i = 0; i < 40; i++)
            begin
               net_valid_i <= 1'b1;
               net_data_i <= 8'(i) ^ 8'h5A;
               do @(posedge clock_i); while (net_ready_o !== 1'b1);
            end
            net_valid_i <= 1'b0;
         end
         while (q.size() < 40)
         begin
            @(posedge clock_i);
            if (tx_valid_o === 1'b1 && tx_ready_i) q.push_back(tx_data_o);
            tx_ready_i <= xs() % 2;
         end
      join
      foreach (q[i]) chk("serial order", q[i], 8'(i) ^ 8'h5A);
      // host commands and link loss
      cmd_valid_i <= 1'b1;
      @(posedge clock_i);
      cmd_valid_i <= 1'b0;
      link_up_i <= 1'b0;
      @(negedge clock_i);
      chk("cmd refused", {rts_o, dtr_o}, 2'h3);
      bus(1'b1, snp_pkg::OFS_CTRL, 32'h0160_0000);
      @(negedge clock_i);
      chk("link low", {rts_o, dtr_o}, 2'h0);
      @(posedge clock_i);
      link_up_i <= 1'b1;
      cmd_valid_i <= 1'b1;
      cmd_modem_i <= 2'h1;
      @(posedge clock_i);
      cmd_modem_i <= 2'h2;
      @(posedge clock_i);
      cmd_valid_i <= 1'b0;
      @(negedge clock_i);
      chk("latest cmd", {rts_o, dtr_o}, 2'h1);
      conclude();
   end
endmodule
bind snp_packer snp_props u_props (.*);
